// File: gain_loader_consts.svh
// Constants for the serial gain word loader
`ifndef GAIN_LOADER_CONSTS_SVH
`define GAIN_LOADER_CONSTS_SVH
`define GL_WORD_BITS 8
`define GL_GAIN_RESET 8'h00
`define GL_CLK_MHZ 40
`define GL_APPLY_NS 30
`define GL_SHUTDOWN_NS 45
`define GL_SETTLE_NS 45
`define GL_POWERUP_US 200
// Nanosecond times round down, never below one cycle
`define GL_APPLY_CYC ((`GL_APPLY_NS * `GL_CLK_MHZ / 1000) < 1 ? 1 : (`GL_APPLY_NS * `GL_CLK_MHZ / 1000))
`define GL_SHUTDOWN_CYC ((`GL_SHUTDOWN_NS * `GL_CLK_MHZ / 1000) < 1 ? 1 : (`GL_SHUTDOWN_NS * `GL_CLK_MHZ / 1000))
`define GL_SETTLE_CYC ((`GL_SETTLE_NS * `GL_CLK_MHZ / 1000) < 1 ? 1 : (`GL_SETTLE_NS * `GL_CLK_MHZ / 1000))
`define GL_POWERUP_CYC (`GL_POWERUP_US * `GL_CLK_MHZ)
`endif

// File: gain_loader_pkg.sv
// Types for the serial gain word loader
package gain_loader_pkg;
	typedef logic [7:0] gain_code_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SHIFT = 3'b010,
		ST_APPLY = 3'b100
	} load_state_e;
endpackage

// File: serial_gain_word_loader.sv
// Serial gain word loader: three-wire load path and shutdown control
`timescale 1ns/1ps
`include "gain_loader_consts.svh"

// What this block does
// - Write cycle starts on enable falling edge
// - Bits captured on serial clock falling edge
// - Gain applied two mclk cycles after the synced enable rise
// - Code 0 to 255 sets linear gain
// - Shutdown accepted anytime, output off 45 ns
// - Gain code kept during shutdown
// - Word loads while shutdown held low
// - Output settles 45 ns after shutdown rise
// - Enable low at power-up gives minimum gain
// - Word shifted in MSB first
// - Latch holds old gain while enable low
// - Enable rise applies word, stops shifting
module serial_gain_word_loader #(
	parameter int POWERUP_CYC = `GL_POWERUP_CYC
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic serial_clk_i,
	input wire logic serial_gain_input_i,
	input wire logic gain_load_enable_n_i,
	input wire logic output_shutdown_n_i,
	output gain_loader_pkg::gain_code_t gain_code_o,
	output logic output_enable_o,
	output logic output_settled_o,
	output logic busy_o
);
	import gain_loader_pkg::*;

	localparam int SD_CYC = `GL_SHUTDOWN_CYC;
	localparam int ST_CYC = `GL_SETTLE_CYC;
	localparam int AP_CYC = `GL_APPLY_CYC;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [1:0] sck_s;
	logic [1:0] sdi_s;
	logic [1:0] en_s;
	logic [1:0] sd_s;
	logic sck_d;
	logic en_d;
	logic sd_d;

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
		begin
			sck_s <= 2'h0;
			sdi_s <= 2'h0;
			en_s <= 2'h3;
			sd_s <= 2'h3;
			sck_d <= 1'b0;
			en_d <= 1'b1;
			sd_d <= 1'b1;
		end
		else
		begin
			sck_s <= {sck_s[0], serial_clk_i};
			sdi_s <= {sdi_s[0], serial_gain_input_i};
			en_s <= {en_s[0], gain_load_enable_n_i};
			sd_s <= {sd_s[0], output_shutdown_n_i};
			sck_d <= sck_s[1];
			en_d <= en_s[1];
			sd_d <= sd_s[1];
		end
	end

	logic sck_fall;
	logic en_fall;
	logic en_rise;
	assign sck_fall = sck_d && !sck_s[1];
	assign en_fall = en_d && !en_s[1];
	assign en_rise = !en_d && en_s[1];

	// ----------------------------------------
	// Load sequence
	// ----------------------------------------
	load_state_e state;
	gain_code_t shift;
	logic pwr_start;

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			state <= ST_IDLE;
		else
		begin
			case (state)
				ST_IDLE:
					if (en_fall)
						state <= ST_SHIFT;
				ST_SHIFT:
					if (en_rise)
						state <= ST_APPLY;
				ST_APPLY:
					state <= ST_IDLE;
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// Shutdown does not gate shifting, so a preload works while off
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			shift <= `GL_GAIN_RESET;
		else if (state == ST_SHIFT && sck_fall)
			shift <= {shift[6:0], sdi_s[1]};
	end

	// Enable already low when reset leaves: start at minimum gain
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			pwr_start <= 1'b1;
		else
			pwr_start <= 1'b0;
	end

	// Latch closed while shifting, loads the shifted word in the one ST_APPLY cycle
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			gain_code_o <= `GL_GAIN_RESET;
		else if (state == ST_APPLY)
			gain_code_o <= shift;
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			busy_o <= 1'b0;
		else
			busy_o <= (state == ST_SHIFT);
	end

	// ----------------------------------------
	// Shutdown and settling
	// ----------------------------------------
	logic [15:0] sd_cnt;
	logic [31:0] pu_cnt;

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			sd_cnt <= 16'h0000;
		else if (sd_s[1] != sd_d)
			sd_cnt <= 16'h0001;
		else if (sd_cnt != 16'h0000 && sd_cnt < 16'(SD_CYC > ST_CYC ? SD_CYC : ST_CYC))
			sd_cnt <= sd_cnt + 16'h0001;
		else
			sd_cnt <= 16'h0000;
	end

	// Outputs follow shutdown after the fixed delay; gain untouched
	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			output_enable_o <= 1'b0;
		else if (!sd_d && sd_cnt == 16'(SD_CYC))
			output_enable_o <= 1'b0;
		else if (sd_d && sd_cnt == 16'(ST_CYC) && pu_cnt == 32'h0)
			output_enable_o <= 1'b1;
		else if (sd_d && sd_cnt == 16'h0000 && pu_cnt == 32'h0)
			output_enable_o <= 1'b1;
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			pu_cnt <= 32'(POWERUP_CYC);
		else if (pu_cnt != 32'h0)
			pu_cnt <= pu_cnt - 32'h1;
	end

	always_ff @(posedge mclk_i)
	begin
		if (!rst_n_i)
			output_settled_o <= 1'b0;
		else
			output_settled_o <= output_enable_o && pu_cnt == 32'h0 && sd_cnt == 16'h0000;
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_load_close;
		state == ST_SHIFT ##1 en_rise;
	endsequence

	a_apply_after_rise: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		s_load_close |-> ##2 gain_code_o == $past(shift, 1))
		else $error("gain not applied after enable rise");
	a_apply_in_time: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		en_rise && state == ST_SHIFT |-> ##[1:AP_CYC] state == ST_APPLY)
		else $error("apply step late after enable rise");
	a_hold_while_shift: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		state == ST_SHIFT && !en_rise |=> $stable(gain_code_o))
		else $error("gain changed while shifting");
	a_msb_first: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		state == ST_SHIFT && sck_fall |=> shift[0] == $past(sdi_s[1]))
		else $error("serial bit not captured");
	a_no_shift_idle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		state == ST_IDLE |=> $stable(shift))
		else $error("shift moved outside a load");
	a_start_on_fall: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		state == ST_IDLE && en_fall |=> state == ST_SHIFT)
		else $error("load did not start");
	a_shutdown_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		$fell(sd_d) ##1 !sd_d [*2] |-> ##0 !output_enable_o)
		else $error("output not off after shutdown");
	a_gain_kept_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		!sd_d && state != ST_APPLY |=> $stable(gain_code_o))
		else $error("gain changed in shutdown");
	a_reenable: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(sd_d) && pu_cnt == 32'h0 |-> ##[1:3] output_enable_o)
		else $error("output not back after shutdown release");
	a_powerup_min: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
		pwr_start |-> gain_code_o == `GL_GAIN_RESET && !output_enable_o)
		else $error("power-up gain not minimum");
endmodule // serial_gain_word_loader

// File: gain_host_model.sv
// Host model that drives the three-wire gain load path
`timescale 1ns/1ps
module gain_host_model (
	input wire logic mclk_i,
	output logic serial_clk_o,
	output logic serial_data_o,
	output logic load_enable_n_o
);
	initial
	begin
		serial_clk_o = 1'b0;
		serial_data_o = 1'b0;
		load_enable_n_o = 1'b1;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	// ----------------------------------------
	// Frame: clock still outside, 4 cycles a level
	// ----------------------------------------
	task automatic send(input logic [15:0] w, input int n, input logic frame);
		if (frame)
			load_enable_n_o <= 1'b0;
		hold(4);
		for (int i = n - 1; i >= 0; i--)
		begin
			serial_data_o <= w[i];
			serial_clk_o <= 1'b1;
			hold(4);
			serial_clk_o <= 1'b0;
			hold(4);
		end
		// Released line must not keep the last bit
		serial_data_o <= ~serial_data_o;
	endtask
	task automatic finish_load();
		load_enable_n_o <= 1'b1;
		hold(4);
	endtask
endmodule // gain_host_model

// File: tb_serial_gain_word_loader.sv
// Testbench for the serial gain word loader
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module tb_serial_gain_word_loader;
	import gain_loader_pkg::*;
	logic mclk;
	logic rst_n;
	logic sd_n;
	logic sclk;
	logic sdat;
	logic len_n;
	gain_code_t gain;
	logic oe;
	logic settled;
	logic busy;
	int n_mismatch = 0;
	int comparisons = 0;
	always #12.5 mclk = ~mclk;
	gain_host_model host (.mclk_i(mclk), .serial_clk_o(sclk), .serial_data_o(sdat),
		.load_enable_n_o(len_n));
	serial_gain_word_loader #(.POWERUP_CYC(20)) DUT (.mclk_i(mclk), .rst_n_i(rst_n),
		.serial_clk_i(sclk), .serial_gain_input_i(sdat), .gain_load_enable_n_i(len_n),
		.output_shutdown_n_i(sd_n), .gain_code_o(gain), .output_enable_o(oe),
		.output_settled_o(settled), .busy_o(busy));
	task automatic test_done();
		$display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic load(input logic [15:0] w, input int n, input gain_code_t ex);
		gain_code_t old;
		old = gain;
		host.send(w, n, 1'b1);
		`CHK("gain while shifting", old, gain)
		`CHK("busy", 1'b1, busy)
		host.finish_load();
		host.hold(2);
		`CHK("gain code", ex, gain)
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		mclk = 1'b0;
		rst_n <= 1'b0;
		sd_n <= 1'b1;
		host.send(16'h0000, 0, 1'b1);
		host.hold(16);
		`CHK("output in reset", 1'b0, oe)
		rst_n <= 1'b1;
		// Enable held low across reset must open a load
		host.hold(5);
		`CHK("load at power-up", 1'b1, busy)
		host.finish_load();
		host.hold(30);
		`CHK("minimum gain", 8'h00, gain)
		`CHK("output on", 1'b1, oe)
		`CHK("settled", 1'b1, settled)
		load(16'h00A5, 8, 8'hA5);
		load(16'h00FF, 8, 8'hFF);
		sd_n <= 1'b0;
		host.hold(6);
		`CHK("output off", 1'b0, oe)
		`CHK("gain kept", 8'hFF, gain)
		load(16'h003C, 8, 8'h3C);
		sd_n <= 1'b1;
		host.hold(6);
		`CHK("output back", 1'b1, oe)
		// Stray clocks with enable high must change nothing
		host.send(16'hFFFF, 8, 1'b0);
		host.hold(6);
		`CHK("gain after stray", 8'h3C, gain)
		// One clock only: stray bits taken would show as FF here
		load(16'h0001, 1, 8'h79);
		load(16'h0281, 10, 8'h81);
		test_done();
	end
endmodule // tb_serial_gain_word_loader
